// *** core/mgt_bus_if.sv ***
// Two-wire open-drain bus joining the host and the sensor
`timescale 1ns/10ps
`default_nettype none
interface mgt_bus_if;
   logic host_scl_o;
   logic host_scl_oe_b;
   logic host_sda_o;
   logic host_sda_oe_b;
   logic dev_sda_o;
   logic dev_sda_oe_b;
   logic scl;
   logic sda;
   // Pull-ups win unless some party drives low
   assign scl = host_scl_oe_b | host_scl_o;
   assign sda = (host_sda_oe_b | host_sda_o) & (dev_sda_oe_b | dev_sda_o);
   modport host (input scl, input sda, output host_scl_o,
      output host_scl_oe_b, output host_sda_o, output host_sda_oe_b);
   modport device (input scl, input sda, output dev_sda_o,
      output dev_sda_oe_b);
endinterface
`default_nettype wire

// *** core/mgt_device.sv ***
// Sensor end: serial target with the measurement register map
`timescale 1ns/10ps
`default_nettype none
`include "mgt_map.svh"
module mgt_device
   import mgt_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = `MGT_DEV_ADDR,
   // Arbitrary identity value
   parameter logic [7:0] PART_ID = `MGT_PART_ID_VAL
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   mgt_bus_if.device bus,
   input wire logic [19:0] x_field_i,
   input wire logic [19:0] y_field_i,
   input wire logic [19:0] z_field_i,
   input wire logic [7:0] temperature_i,
   input wire logic [7:0] status_i,
   output logic [7:0] measurement_rate_setting_o,
   output logic [7:0] control_zero_o,
   output logic [7:0] control_one_o,
   output logic [7:0] control_two_o,
   output logic [23:0] selftest_limit_o,
   output logic [23:0] selftest_reference_o,
   output logic fast_rate_o,
   output logic restore_pulse_o,
   output logic wr_pulse_o
);
   logic [1:0] sync1_reg;
   logic [1:0] sync2_reg;
   logic [1:0] sync3_reg;
   logic [1:0] filt_reg;
   logic [1:0] filt_prev_reg;
   logic [1:0] filt_next;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   mgt_dev_state_t state_reg;
   logic [3:0] cnt_reg;
   logic [7:0] rx_reg;
   logic [7:0] tx_reg;
   logic [7:0] ptr_reg;
   logic rw_reg;
   logic master_ack_reg;
   logic sda_drv_reg;
   logic [7:0] rate_reg;
   logic [7:0] ctrl0_reg;
   logic [7:0] ctrl1_reg;
   logic [7:0] ctrl2_reg;
   logic [7:0] limit_reg [3];
   logic [7:0] ref_reg [3];
   logic wr_en;
   logic [7:0] rd_byte;

   // Bit 1 is the clock line, bit 0 the data line
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync1_reg <= 2'h3;
         sync2_reg <= 2'h3;
         sync3_reg <= 2'h3;
      end else begin
         sync1_reg <= {bus.scl, bus.sda};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // A level counts once the second and third stage agree
   assign filt_next = (~(sync2_reg ^ sync3_reg) & sync2_reg) |
                      ((sync2_reg ^ sync3_reg) & filt_reg);

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         filt_reg <= 2'h3;
         filt_prev_reg <= 2'h3;
      end else begin
         filt_reg <= filt_next;
         filt_prev_reg <= filt_reg;
      end
   end

   assign scl = filt_reg[1];
   assign sda = filt_reg[0];
   assign scl_rise = scl & ~filt_prev_reg[1];
   assign scl_fall = ~scl & filt_prev_reg[1];
   // Data edges under a high clock frame the transfers
   assign start_seen = scl & filt_prev_reg[1] & ~sda & filt_prev_reg[0];
   assign stop_seen = scl & filt_prev_reg[1] & sda & ~filt_prev_reg[0];

   always_comb begin
      unique case (ptr_reg)
         `MGT_X_UPPER: rd_byte = x_field_i[19:12];
         `MGT_X_MIDDLE: rd_byte = x_field_i[11:4];
         `MGT_X_LOWER: rd_byte = {x_field_i[3:0], 4'h0};
         `MGT_Y_UPPER: rd_byte = y_field_i[19:12];
         `MGT_Y_MIDDLE: rd_byte = y_field_i[11:4];
         `MGT_Y_LOWER: rd_byte = {y_field_i[3:0], 4'h0};
         `MGT_Z_UPPER: rd_byte = z_field_i[19:12];
         `MGT_Z_MIDDLE: rd_byte = z_field_i[11:4];
         `MGT_Z_LOWER: rd_byte = {z_field_i[3:0], 4'h0};
         `MGT_TEMP: rd_byte = temperature_i;
         `MGT_STATUS: rd_byte = status_i;
         `MGT_RATE: rd_byte = rate_reg;
         `MGT_CTRL0: rd_byte = ctrl0_reg;
         `MGT_CTRL1: rd_byte = ctrl1_reg;
         `MGT_CTRL2: rd_byte = ctrl2_reg;
         `MGT_X_LIMIT: rd_byte = limit_reg[0];
         `MGT_Y_LIMIT: rd_byte = limit_reg[1];
         `MGT_Z_LIMIT: rd_byte = limit_reg[2];
         `MGT_X_REF: rd_byte = ref_reg[0];
         `MGT_Y_REF: rd_byte = ref_reg[1];
         `MGT_Z_REF: rd_byte = ref_reg[2];
         `MGT_PART_ID: rd_byte = PART_ID;
         default: rd_byte = 8'h00;
      endcase
   end

   assign wr_en = scl_fall && (state_reg == DEV_WR) && (cnt_reg == 4'h8);

   // Transfer sequencing; leaves idle only on a master's start
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg <= DEV_IDLE;
         cnt_reg <= 4'h0;
         rx_reg <= 8'h00;
         tx_reg <= 8'h00;
         ptr_reg <= 8'h00;
         rw_reg <= 1'b0;
         master_ack_reg <= 1'b0;
         sda_drv_reg <= 1'b1;
      end else if (start_seen) begin
         state_reg <= DEV_ADDR_RX;
         cnt_reg <= 4'h0;
         sda_drv_reg <= 1'b1;
      end else if (stop_seen) begin
         state_reg <= DEV_IDLE;
         sda_drv_reg <= 1'b1;
      end else if (scl_rise) begin
         if (state_reg == DEV_RD_ACK) begin
            master_ack_reg <= ~sda;
         end else if (state_reg != DEV_IDLE) begin
            rx_reg <= {rx_reg[6:0], sda};
            cnt_reg <= cnt_reg + 4'h1;
         end
      end else if (scl_fall) begin
         // Own drive changes only right after the clock falls
         unique case (state_reg)
            DEV_IDLE: sda_drv_reg <= 1'b1;
            DEV_ADDR_RX: begin
               if (cnt_reg == 4'h8) begin
                  if (rx_reg[7:1] == DEV_ADDR) begin
                     rw_reg <= rx_reg[0];
                     sda_drv_reg <= 1'b0;
                     state_reg <= DEV_ADDR_ACK;
                  end else begin
                     state_reg <= DEV_IDLE;
                  end
               end
            end
            DEV_ADDR_ACK: begin
               cnt_reg <= 4'h0;
               if (rw_reg) begin
                  sda_drv_reg <= rd_byte[7];
                  tx_reg <= {rd_byte[6:0], 1'b0};
                  state_reg <= DEV_RD;
               end else begin
                  sda_drv_reg <= 1'b1;
                  state_reg <= DEV_REG;
               end
            end
            DEV_REG: begin
               if (cnt_reg == 4'h8) begin
                  ptr_reg <= rx_reg;
                  sda_drv_reg <= 1'b0;
                  state_reg <= DEV_REG_ACK;
               end
            end
            DEV_REG_ACK, DEV_WR_ACK: begin
               cnt_reg <= 4'h0;
               sda_drv_reg <= 1'b1;
               state_reg <= DEV_WR;
            end
            DEV_WR: begin
               if (cnt_reg == 4'h8) begin
                  ptr_reg <= ptr_reg + 8'h01;
                  sda_drv_reg <= 1'b0;
                  state_reg <= DEV_WR_ACK;
               end
            end
            DEV_RD: begin
               if (cnt_reg == 4'h8) begin
                  ptr_reg <= ptr_reg + 8'h01;
                  sda_drv_reg <= 1'b1;
                  state_reg <= DEV_RD_ACK;
               end else begin
                  sda_drv_reg <= tx_reg[7];
                  tx_reg <= {tx_reg[6:0], 1'b0};
               end
            end
            DEV_RD_ACK: begin
               cnt_reg <= 4'h0;
               // A not-acknowledge ends the read burst
               if (master_ack_reg) begin
                  sda_drv_reg <= rd_byte[7];
                  tx_reg <= {rd_byte[6:0], 1'b0};
                  state_reg <= DEV_RD;
               end else begin
                  state_reg <= DEV_IDLE;
               end
            end
            default: state_reg <= DEV_IDLE;
         endcase
      end
   end

   // Writable registers; read-only and unmapped addresses drop writes
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rate_reg <= `MGT_RW_RESET;
         ctrl0_reg <= `MGT_RW_RESET;
         ctrl1_reg <= `MGT_RW_RESET;
         ctrl2_reg <= `MGT_RW_RESET;
         for (int i = 0; i < 3; i++) begin
            limit_reg[i] <= `MGT_RW_RESET;
            ref_reg[i] <= `MGT_RW_RESET;
         end
      end else if (wr_en) begin
         unique case (ptr_reg)
            `MGT_RATE: rate_reg <= rx_reg;
            `MGT_CTRL0: ctrl0_reg <= rx_reg;
            `MGT_CTRL1: ctrl1_reg <= rx_reg;
            `MGT_CTRL2: ctrl2_reg <= rx_reg;
            `MGT_X_LIMIT: limit_reg[0] <= rx_reg;
            `MGT_Y_LIMIT: limit_reg[1] <= rx_reg;
            `MGT_Z_LIMIT: limit_reg[2] <= rx_reg;
            `MGT_X_REF: ref_reg[0] <= rx_reg;
            `MGT_Y_REF: ref_reg[1] <= rx_reg;
            `MGT_Z_REF: ref_reg[2] <= rx_reg;
            default: ;
         endcase
      end
   end

   // Strobes and the registered fast-rate level for the measurement core
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_pulse_o <= 1'b0;
         restore_pulse_o <= 1'b0;
         fast_rate_o <= 1'b0;
      end else begin
         wr_pulse_o <= wr_en;
         restore_pulse_o <= wr_en && (ptr_reg == `MGT_CTRL0) &&
                            rx_reg[`MGT_RESTORE_BIT];
         fast_rate_o <= (rate_reg == `MGT_RATE_FAST) &&
                        ctrl2_reg[`MGT_HPOWER_BIT];
      end
   end

   assign measurement_rate_setting_o = rate_reg;
   assign control_zero_o = ctrl0_reg;
   assign control_one_o = ctrl1_reg;
   assign control_two_o = ctrl2_reg;
   assign selftest_limit_o = {limit_reg[2], limit_reg[1], limit_reg[0]};
   assign selftest_reference_o = {ref_reg[2], ref_reg[1], ref_reg[0]};
   // Only ever pulls low or lets go
   assign bus.dev_sda_o = 1'b0;
   assign bus.dev_sda_oe_b = sda_drv_reg;
endmodule
`default_nettype wire

// *** core/mgt_host.sv ***
// Host end: bus master running one register write or read per request
`timescale 1ns/10ps
`default_nettype none
`include "mgt_map.svh"
module mgt_host
   import mgt_pkg::*;
#(
   parameter int QTR_CYC = `MGT_QTR_CYC
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   mgt_bus_if.host bus,
   input wire logic go_i,
   input wire logic read_i,
   input wire logic [6:0] dev_addr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] wr_data_i,
   output logic busy_o,
   output logic done_o,
   output logic nack_o,
   output logic [7:0] rd_data_o
);
   logic [1:0] sync1_reg;
   logic [1:0] sync2_reg;
   logic [1:0] sync3_reg;
   logic [1:0] filt_reg;
   mgt_host_state_t state_reg;
   logic [15:0] qcnt_reg;
   logic [1:0] ph_reg;
   logic [3:0] idx_reg;
   logic [2:0] step_reg;
   logic rd_reg;
   logic [6:0] addr_reg;
   logic [7:0] regad_reg;
   logic [7:0] wdat_reg;
   logic scl_drv_reg;
   logic sda_drv_reg;
   mgt_sym_t sym;
   logic [7:0] tx_byte;
   logic [2:0] last_step;
   logic val_a;
   logic val_b;
   logic qend;

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync1_reg <= 2'h3;
         sync2_reg <= 2'h3;
         sync3_reg <= 2'h3;
         filt_reg <= 2'h3;
      end else begin
         sync1_reg <= {bus.scl, bus.sda};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         filt_reg <= (~(sync2_reg ^ sync3_reg) & sync2_reg) |
                     ((sync2_reg ^ sync3_reg) & filt_reg);
      end
   end

   assign last_step = rd_reg ? 3'd6 : 3'd4;

   always_comb begin
      tx_byte = {addr_reg, 1'b0};
      unique case (step_reg)
         3'd0: sym = SYM_START;
         3'd1: sym = SYM_WBYTE;
         3'd2: begin
            sym = SYM_WBYTE;
            tx_byte = regad_reg;
         end
         3'd3: begin
            sym = rd_reg ? SYM_START : SYM_WBYTE;
            tx_byte = wdat_reg;
         end
         3'd4: begin
            sym = rd_reg ? SYM_WBYTE : SYM_STOP;
            tx_byte = {addr_reg, 1'b1};
         end
         3'd5: sym = SYM_RBYTE;
         default: sym = SYM_STOP;
      endcase
   end

   // Level under the high clock (a) and in its second half (b)
   always_comb begin
      unique case (sym)
         SYM_START: begin
            val_a = 1'b1;
            val_b = 1'b0;
         end
         SYM_STOP: begin
            val_a = 1'b0;
            val_b = 1'b1;
         end
         SYM_WBYTE: begin
            val_a = (idx_reg == 4'h8) ? 1'b1 : tx_byte[3'd7 - idx_reg[2:0]];
            val_b = val_a;
         end
         SYM_RBYTE: begin
            val_a = 1'b1;
            val_b = 1'b1;
         end
      endcase
   end

   assign qend = (qcnt_reg == 16'(QTR_CYC - 1));

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg <= HOST_IDLE;
         qcnt_reg <= 16'h0000;
         ph_reg <= 2'h0;
         idx_reg <= 4'h0;
         step_reg <= 3'd0;
         rd_reg <= 1'b0;
         addr_reg <= 7'h00;
         regad_reg <= 8'h00;
         wdat_reg <= 8'h00;
         scl_drv_reg <= 1'b1;
         sda_drv_reg <= 1'b1;
         done_o <= 1'b0;
         nack_o <= 1'b0;
         rd_data_o <= 8'h00;
      end else begin
         done_o <= 1'b0;
         unique case (state_reg)
            HOST_IDLE: begin
               if (go_i) begin
                  rd_reg <= read_i;
                  addr_reg <= dev_addr_i;
                  regad_reg <= reg_addr_i;
                  wdat_reg <= wr_data_i;
                  nack_o <= 1'b0;
                  state_reg <= HOST_WAIT;
               end
            end
            HOST_WAIT: begin
               // Begin only on a free bus
               if (filt_reg == 2'h3) begin
                  step_reg <= 3'd0;
                  idx_reg <= 4'h0;
                  ph_reg <= 2'h0;
                  qcnt_reg <= 16'h0000;
                  state_reg <= HOST_RUN;
               end
            end
            HOST_RUN: begin
               qcnt_reg <= qend ? 16'h0000 : qcnt_reg + 16'h0001;
               if (qend) begin
                  ph_reg <= ph_reg + 2'h1;
                  // Data moves a quarter after the clock falls
                  unique case (ph_reg)
                     2'h0: sda_drv_reg <= val_a;
                     2'h1: scl_drv_reg <= 1'b1;
                     2'h2: sda_drv_reg <= val_b;
                     2'h3: begin
                        if (sym == SYM_WBYTE && idx_reg == 4'h8) begin
                           nack_o <= nack_o | filt_reg[0];
                        end
                        if (sym == SYM_RBYTE && idx_reg != 4'h8) begin
                           rd_data_o <= {rd_data_o[6:0], filt_reg[0]};
                        end
                        if ((sym == SYM_WBYTE || sym == SYM_RBYTE) &&
                            idx_reg != 4'h8) begin
                           idx_reg <= idx_reg + 4'h1;
                           scl_drv_reg <= 1'b0;
                        end else if (step_reg == last_step) begin
                           done_o <= 1'b1;
                           state_reg <= HOST_IDLE;
                        end else begin
                           idx_reg <= 4'h0;
                           scl_drv_reg <= 1'b0;
                           // A refused byte skips straight to the stop
                           if (sym == SYM_WBYTE && filt_reg[0]) begin
                              step_reg <= last_step;
                           end else begin
                              step_reg <= step_reg + 3'd1;
                           end
                        end
                     end
                  endcase
               end
            end
            default: state_reg <= HOST_IDLE;
         endcase
      end
   end

   assign busy_o = (state_reg != HOST_IDLE);
   // Pull low or release only
   assign bus.host_scl_o = 1'b0;
   assign bus.host_scl_oe_b = scl_drv_reg;
   assign bus.host_sda_o = 1'b0;
   assign bus.host_sda_oe_b = sda_drv_reg;
endmodule
`default_nettype wire

// *** core/mgt_map.svh ***
// Register offsets, field positions and timing counts of the sensor link
`ifndef MGT_MAP_SVH
`define MGT_MAP_SVH
`define MGT_X_UPPER 8'h00
`define MGT_X_MIDDLE 8'h01
`define MGT_Y_UPPER 8'h02
`define MGT_Y_MIDDLE 8'h03
`define MGT_Z_UPPER 8'h04
`define MGT_Z_MIDDLE 8'h05
`define MGT_X_LOWER 8'h06
`define MGT_Y_LOWER 8'h07
`define MGT_Z_LOWER 8'h08
`define MGT_TEMP 8'h09
`define MGT_STATUS 8'h18
`define MGT_RATE 8'h1a
`define MGT_CTRL0 8'h1b
`define MGT_CTRL1 8'h1c
`define MGT_CTRL2 8'h1d
`define MGT_X_LIMIT 8'h1e
`define MGT_Y_LIMIT 8'h1f
`define MGT_Z_LIMIT 8'h20
`define MGT_X_REF 8'h27
`define MGT_Y_REF 8'h28
`define MGT_Z_REF 8'h29
`define MGT_PART_ID 8'h39
`define MGT_RW_RESET 8'h00
`define MGT_RATE_FAST 8'hff
`define MGT_HPOWER_BIT 7
`define MGT_RESTORE_BIT 3
`define MGT_DEV_ADDR 7'h30
`define MGT_PART_ID_VAL 8'h5a
`define MGT_CLK_PERIOD_NS 10
`define MGT_SCL_PERIOD_NS 2500
`define MGT_QTR_CYC \
   ((`MGT_SCL_PERIOD_NS + 4 * `MGT_CLK_PERIOD_NS - 1) / \
    (4 * `MGT_CLK_PERIOD_NS))
`endif

// *** core/mgt_pkg.sv ***
// Shared types of the sensor link ends
`default_nettype none
package mgt_pkg;
   typedef enum logic [3:0] {
      DEV_IDLE, DEV_ADDR_RX, DEV_ADDR_ACK, DEV_REG, DEV_REG_ACK,
      DEV_WR, DEV_WR_ACK, DEV_RD, DEV_RD_ACK
   } mgt_dev_state_t;
   typedef enum logic [1:0] {HOST_IDLE, HOST_WAIT, HOST_RUN} mgt_host_state_t;
   typedef enum logic [1:0] {
      SYM_START, SYM_WBYTE, SYM_RBYTE, SYM_STOP
   } mgt_sym_t;
endpackage
`default_nettype wire

// *** testbench/mgt_bus_asserts.sv ***
// Bus rule checker watching both ends of the sensor link
`timescale 1ns/10ps
`default_nettype none
module mgt_bus_asserts (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic scl,
   input wire logic sda,
   input wire logic host_scl_o,
   input wire logic host_scl_oe_b,
   input wire logic host_sda_o,
   input wire logic host_sda_oe_b,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe_b
);
   logic scl_q_reg;
   logic sda_q_reg;
   logic frame_reg;
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
      end else begin
         scl_q_reg <= scl;
         sda_q_reg <= sda;
      end
   end
   // Frame tracked from the wire itself, not from either end's state
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         frame_reg <= 1'b0;
      end else if (scl && scl_q_reg && sda_q_reg && !sda) begin
         frame_reg <= 1'b1;
      end else if (scl && scl_q_reg && !sda_q_reg && sda) begin
         frame_reg <= 1'b0;
      end
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   dev_stable_high_a:
      assert property (scl && $past(scl) |-> $stable(dev_sda_oe_b))
      else $error("Device data moved with clock high");
   host_stop_edge_a:
      assert property ($rose(host_sda_oe_b) && scl |=> !frame_reg)
      else $error("Host data rose in clock high without stop");
   host_start_edge_a:
      assert property ($fell(host_sda_oe_b) && scl |=> frame_reg)
      else $error("Host data fell in clock high without start");
   drive_zero_a:
      assert property (!host_scl_o && !host_sda_o && !dev_sda_o)
      else $error("A party drives a line high");
   dev_pull_low_a:
      assert property ($fell(dev_sda_oe_b) |-> !scl)
      else $error("Device took data line with clock high");
   reset_release_a:
      assert property ($rose(rst_b_i) |-> host_scl_oe_b && host_sda_oe_b
         && dev_sda_oe_b)
      else $error("Line held low out of reset");
   dev_in_frame_a:
      assert property (!dev_sda_oe_b |-> frame_reg)
      else $error("Device drives data outside a frame");
   host_idle_a:
      assert property (!frame_reg |-> host_scl_oe_b)
      else $error("Host clocks without a start");
   start_free_a:
      assert property ($fell(sda) && scl && !frame_reg |->
         $past(scl, 3) && $past(sda, 3))
      else $error("Start on a busy bus");
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking bench: host end against sensor end over the bus
`timescale 1ns/10ps
`default_nettype none
`include "mgt_map.svh"
module tb;
   import mgt_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic go_i = 1'b0;
   logic read_i = 1'b0;
   logic [6:0] dev_addr_i = `MGT_DEV_ADDR;
   logic [7:0] reg_addr_i = 8'h00;
   logic [7:0] wr_data_i = 8'h00;
   logic [7:0] temperature_i = 8'h00;
   logic [7:0] status_i = 8'h00;
   logic [19:0] x_field_i = 20'h0;
   logic [19:0] y_field_i = 20'h0;
   logic [19:0] z_field_i = 20'h0;
   logic busy_o, done_o, nack_o, fast_o, restore_o, wr_pulse_o;
   logic [7:0] rd_data_o, rate_o, ctl0_o, ctl1_o, ctl2_o;
   logic [23:0] lim_o, ref_o;
   int num_errors = 0;
   int n_checks = 0;
   int n_restore = 0;
   int n_wr = 0;
   logic [7:0] model [0:255];
   logic [7:0] rw_list [10] = '{`MGT_RATE, `MGT_CTRL0, `MGT_CTRL1,
      `MGT_CTRL2, `MGT_X_LIMIT, `MGT_Y_LIMIT, `MGT_Z_LIMIT, `MGT_X_REF,
      `MGT_Y_REF, `MGT_Z_REF};
   mgt_bus_if mgt_bus_if_inst ();
   mgt_host #(.QTR_CYC(6)) mgt_host_inst (.ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i), .bus(mgt_bus_if_inst.host), .go_i(go_i),
      .read_i(read_i), .dev_addr_i(dev_addr_i), .reg_addr_i(reg_addr_i),
      .wr_data_i(wr_data_i), .busy_o(busy_o), .done_o(done_o),
      .nack_o(nack_o), .rd_data_o(rd_data_o));
   mgt_device mgt_device_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .bus(mgt_bus_if_inst.device), .x_field_i(x_field_i),
      .y_field_i(y_field_i), .z_field_i(z_field_i),
      .temperature_i(temperature_i), .status_i(status_i),
      .measurement_rate_setting_o(rate_o), .control_zero_o(ctl0_o),
      .control_one_o(ctl1_o), .control_two_o(ctl2_o),
      .selftest_limit_o(lim_o), .selftest_reference_o(ref_o),
      .fast_rate_o(fast_o), .restore_pulse_o(restore_o),
      .wr_pulse_o(wr_pulse_o));
   mgt_bus_asserts mgt_bus_asserts_inst (.ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i), .scl(mgt_bus_if_inst.scl),
      .sda(mgt_bus_if_inst.sda),
      .host_scl_o(mgt_bus_if_inst.host_scl_o),
      .host_scl_oe_b(mgt_bus_if_inst.host_scl_oe_b),
      .host_sda_o(mgt_bus_if_inst.host_sda_o),
      .host_sda_oe_b(mgt_bus_if_inst.host_sda_oe_b),
      .dev_sda_o(mgt_bus_if_inst.dev_sda_o),
      .dev_sda_oe_b(mgt_bus_if_inst.dev_sda_oe_b));
   initial begin
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) begin
      if (restore_o === 1'b1) n_restore++;
      if (wr_pulse_o === 1'b1) n_wr++;
   end
   task automatic results();
      $display("Checks %0d, mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] expect_rd(input logic [7:0] a);
      case (a)
         `MGT_X_UPPER: return x_field_i[19:12];
         `MGT_X_MIDDLE: return x_field_i[11:4];
         `MGT_X_LOWER: return {x_field_i[3:0], 4'h0};
         `MGT_Y_UPPER: return y_field_i[19:12];
         `MGT_Y_MIDDLE: return y_field_i[11:4];
         `MGT_Y_LOWER: return {y_field_i[3:0], 4'h0};
         `MGT_Z_UPPER: return z_field_i[19:12];
         `MGT_Z_MIDDLE: return z_field_i[11:4];
         `MGT_Z_LOWER: return {z_field_i[3:0], 4'h0};
         `MGT_TEMP: return temperature_i;
         `MGT_STATUS: return status_i;
         default: return model[a];
      endcase
   endfunction
   // One whole host transfer; done_o is looked at in its single cycle
   task automatic xfer(input logic rd, input logic [7:0] a,
      input logic [7:0] d);
      int n;
      @(negedge ref_clk_i);
      read_i = rd;
      reg_addr_i = a;
      wr_data_i = d;
      go_i = 1'b1;
      @(negedge ref_clk_i);
      go_i = 1'b0;
      n = 0;
      while (done_o !== 1'b1 && n < 3000) begin
         @(negedge ref_clk_i);
         n++;
      end
      if (n >= 3000) num_errors++;
      check(24'(busy_o), 24'h0);
   endtask
   // Every written byte strobes once, even where the write is dropped
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      n_wr = 0;
      xfer(1'b0, a, d);
      if (a inside {rw_list}) model[a] = d;
      check(24'(nack_o), 24'h0);
      check(24'(n_wr), 24'h1);
   endtask
   task automatic rd_chk(input logic [7:0] a);
      xfer(1'b1, a, 8'h00);
      check(24'(rd_data_o), 24'(expect_rd(a)));
   endtask
   // Span of about 100 transfers; a hang ends the run as a failure
   initial begin
      #(90000 * 10);
      num_errors++;
      results();
   end
   initial begin
      void'($urandom(32'h0249));
      for (int i = 0; i < 256; i++) model[i] = 8'h00;
      model[`MGT_PART_ID] = `MGT_PART_ID_VAL;
      repeat (10) @(negedge ref_clk_i);
      rst_b_i = 1'b1;
      repeat (3) @(negedge ref_clk_i);
      foreach (rw_list[i]) rd_chk(rw_list[i]);
      rd_chk(`MGT_PART_ID);
      x_field_i = 20'($urandom);
      y_field_i = 20'($urandom);
      z_field_i = 20'($urandom);
      temperature_i = 8'($urandom);
      status_i = 8'($urandom);
      for (int a = 0; a < 10; a++) rd_chk(8'(a));
      rd_chk(`MGT_TEMP);
      rd_chk(`MGT_STATUS);
      foreach (rw_list[i]) begin
         wr(rw_list[i], 8'($urandom));
         rd_chk(rw_list[i]);
      end
      check(lim_o, {model[8'h20], model[8'h1f], model[8'h1e]});
      check(ref_o, {model[8'h29], model[8'h28], model[8'h27]});
      check({rate_o, ctl0_o, ctl1_o},
         {model[8'h1a], model[8'h1b], model[8'h1c]});
      check(24'(ctl2_o), 24'(model[8'h1d]));
      // Read-only and unmapped places ignore writes
      wr(`MGT_X_UPPER, 8'ha5);
      rd_chk(`MGT_X_UPPER);
      wr(8'h0a, 8'h3c);
      rd_chk(8'h0a);
      wr(`MGT_PART_ID, 8'hc3);
      rd_chk(`MGT_PART_ID);
      wr(`MGT_RATE, 8'hfe);
      wr(`MGT_CTRL2, 8'h80);
      check(24'(fast_o), 24'h0);
      wr(`MGT_RATE, `MGT_RATE_FAST);
      check(24'(fast_o), 24'h1);
      wr(`MGT_CTRL2, 8'h00);
      check(24'(fast_o), 24'h0);
      n_restore = 0;
      wr(`MGT_CTRL0, 8'h08);
      wr(`MGT_CTRL0, 8'hf7);
      check(24'(n_restore), 24'h1);
      dev_addr_i = `MGT_DEV_ADDR ^ 7'h01;
      xfer(1'b1, `MGT_TEMP, 8'h00);
      check(24'(nack_o), 24'h1);
      dev_addr_i = `MGT_DEV_ADDR;
      rd_chk(`MGT_CTRL0);
      results();
   end
endmodule
`default_nettype wire
